// ---- csd_pkg.sv ----
// Package: constants, types and helpers of the cycle-steal DMA
package csd_pkg;
   // ======================================================
   // Sizes
   localparam int NCH   = 4;
   localparam int CNT_W = 25;
   localparam int IIO_N = 12;
   // ======================================================
   // Modes, item sizes, bus widths
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_REPEAT = 2'h3;
   localparam logic [1:0] SZ_8  = 2'h0;
   localparam logic [1:0] SZ_16 = 2'h1;
   localparam logic [1:0] BW_32 = 2'h2;
   // ======================================================
   // Register map: channel c at c*32, status at 0x80
   localparam int         CH_SH      = 5;
   localparam logic [4:0] OFS_MODE   = 5'h00;
   localparam logic [4:0] OFS_COUNT  = 5'h04;
   localparam logic [4:0] OFS_RELOAD = 5'h08;
   localparam logic [4:0] OFS_SRC    = 5'h0c;
   localparam logic [4:0] OFS_SRC_RL = 5'h10;
   localparam logic [4:0] OFS_DST    = 5'h14;
   localparam logic [4:0] OFS_DST_RL = 5'h18;
   localparam logic [4:0] OFS_SEL    = 5'h1c;
   localparam logic [7:0] ADR_STATUS = 8'h80;
   // Field positions
   localparam int MODE_POS = 0;
   localparam int SIZE_POS = 2;
   localparam int SINC_POS = 4;
   localparam int DINC_POS = 5;
   localparam int PRI_POS  = 0;
   localparam int EXT_POS  = 8;
   localparam int SW_POS   = 16;
   // Reset values
   localparam logic [5:0]  RST_CTL = 6'h00;
   localparam logic [12:0] RST_SEL = 13'h0000;
   localparam logic [31:0] RST_PTR = 32'h0000_0000;
   localparam logic [CNT_W-1:0] RST_CNT = 25'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 25'h1;
   // ======================================================
   // Request codes
   localparam logic [4:0] PRI_EXT  = 5'h00;
   localparam logic [4:0] PRI_FALL = 5'h01;
   localparam logic [4:0] PRI_BOTH = 5'h02;
   localparam logic [4:0] PRI_TA0  = 5'h03;
   localparam logic [4:0] PRI_ADC  = 5'h18;
   localparam logic [4:0] PRI_IIO0 = 5'h19;
   localparam logic [4:0] EXT_SW   = 5'h00;
   localparam logic [4:0] EXT_SBI0 = 5'h04;
   localparam logic [4:0] EXT_SBI1 = 5'h05;
   localparam logic [4:0] EXT_U3TX = 5'h18;
   localparam logic [4:0] EXT_U4RX = 5'h1b;
   localparam logic [4:0] IIO_BASE [NCH] = '{5'h00, 5'h07, 5'h02, 5'h09};

   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_WRITE, ST_DECR, ST_YIELD
   } csd_state_t;

   // Bytes in one item
   function automatic logic [2:0] csd_item_bytes(input logic [1:0] sz);
      return (sz == SZ_8) ? 3'h1 : (sz == SZ_16) ? 3'h2 : 3'h4;
   endfunction : csd_item_bytes

   // Bytes one bus cycle moves: up to the next lane boundary
   function automatic logic [2:0] csd_piece(input logic [2:0] a,
      input logic [1:0] bw, input logic [2:0] rem);
      logic [3:0] wb;
      logic [3:0] av;
      wb = 4'h1 << bw;
      av = wb - ({1'b0, a} & (wb - 4'h1));
      return (av < {1'b0, rem}) ? av[2:0] : rem;
   endfunction : csd_piece
endpackage : csd_pkg

// ---- csd_dma_top.sv ----
// Four-channel cycle-steal DMA controller with Avalon-MM registers
// Notes on behaviour
// - Four channels, one 8/16/32-bit item per request
// - Pending channel takes data bus before CPU
// - Pointers reach both halves of 64-Mbyte space
// - Count covers up to 32M-1 items of any size
// - Fixed priority, channel 0 highest, 3 lowest
// - Single mode stops when count hits zero
// - Repeat mode reloads count and both pointers
// - Done pulse when count goes one to zero
// - Start only with nonzero count, mode 01/11
// - Mode 00 stops accepting new transfers
// - Software bit or selected hardware request
// - Requests ignore interrupt masks and controls
// - Transfers never touch source pending flags
// - Primary 0 extended, 1 fall, 2 both edges
// - Primary 3-19 timers, serial; 24 converter
// - Codes 25-31 pick I/O lines modulo 12
// - Pin edges independent of interrupt pin setup
// - Extended: software, serial-bus, serial 3/4
// - Source reads then destination writes
// - 16-bit items add cycles by alignment
// - 32-bit items add cycles by alignment
// - Each pointer incrementing or fixed
// - Repeated triggers before grant give one transfer
// - Bus returns to CPU after each transfer
// - Accepted transfer completes despite disable
`timescale 1ns/1ps
module csd_dma_top
   import csd_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic [3:0]  i_ext_request_pin,
   input  wire logic [4:0]  i_timer_a_req,
   input  wire logic [5:0]  i_timer_b_req,
   input  wire logic [2:0]  i_uart_tx_req,
   input  wire logic [2:0]  i_uart_rx_req,
   input  wire logic        i_adc_req,
   input  wire logic [11:0] i_iio_req,
   input  wire logic [1:0]  i_sbi_req,
   input  wire logic [3:0]  i_uart34_req,
   output logic             o_bus_hold,
   input  wire logic        i_cpu_bus_req,
   input  wire logic        i_cpu_access_done,
   output logic             o_mem_req,
   output logic             o_mem_we,
   output logic      [31:0] o_mem_addr,
   output logic      [2:0]  o_mem_nbytes,
   output logic      [31:0] o_mem_wdata,
   input  wire logic [31:0] i_mem_rdata,
   input  wire logic        i_mem_ack,
   input  wire logic [1:0]  i_bus_width,
   output logic      [3:0]  o_xfer_done
);
   // ======================================================
   // Channel state
   logic [5:0]       ctl_r [NCH];
   logic [12:0]      sel_r [NCH];
   logic [CNT_W-1:0] cnt_r [NCH];
   logic [CNT_W-1:0] rl_r  [NCH];
   logic [31:0]      src_r [NCH];
   logic [31:0]      srl_r [NCH];
   logic [31:0]      dst_r [NCH];
   logic [31:0]      drl_r [NCH];
   logic [3:0]       pend_r;
   logic [3:0]       enabled;
   logic [3:0]       elig;
   logic [3:0]       req_hit;
   logic [3:0]       take;
   logic [3:0]       sw_hit;
   logic [1:0]       pick;
   csd_state_t       st_r;
   logic [1:0]       act_r;
   logic [2:0]       szb_r;
   logic [2:0]       rem_r;
   logic [2:0]       got_r;
   logic [31:0]      data_r;
   logic [2:0]       piece_w;
   logic [31:0]      rd_in;
   logic [31:0]      act_src;
   logic             wait_r;
   logic             wr_go;
   logic [1:0]       a_ch;
   logic [4:0]       a_ofs;
   logic [31:0]      rd_mux;
   logic [3:0]       pin_s1_r;
   logic [3:0]       pin_s2_r;
   logic [3:0]       pin_s3_r;
   logic [3:0]       pin_fall;
   logic [3:0]       pin_both;
   logic [24:0]      hw_vec;

   // Byte-enable merge of a bus write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // Request source chosen by one channel's select codes
   function automatic logic sel_req(input logic [1:0] ch,
      input logic [12:0] sel, input logic sw, input logic fall,
      input logic both);
      logic       r;
      logic [4:0] p;
      logic [4:0] e;
      logic [4:0] k;
      r = 1'b0;
      p = sel[PRI_POS +: 5];
      e = sel[EXT_POS +: 5];
      k = IIO_BASE[ch] + (p - PRI_IIO0);
      if (k >= 5'(IIO_N)) begin
         k = k - 5'(IIO_N);
      end
      if (p == PRI_EXT) begin
         if (e == EXT_SW) begin
            r = sw;
         end else if (e == EXT_SBI0) begin
            r = i_sbi_req[0];
         end else if (e == EXT_SBI1) begin
            r = i_sbi_req[1];
         end else if (e >= EXT_U3TX && e <= EXT_U4RX) begin
            r = i_uart34_req[e[1:0]];
         end
      end else if (p == PRI_FALL) begin
         r = fall;
      end else if (p == PRI_BOTH) begin
         r = both;
      end else if (p <= PRI_ADC) begin
         r = hw_vec[p];
      end else begin
         r = i_iio_req[k[3:0]];
      end
      return r;
   endfunction : sel_req

   // ======================================================
   // Pin synchronisers and edge detect; no interrupt-pin
   // polarity or level setting reaches this path
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         pin_s1_r <= 4'hf;
         pin_s2_r <= 4'hf;
         pin_s3_r <= 4'hf;
      end else begin
         pin_s1_r <= i_ext_request_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end
   assign pin_fall = pin_s3_r & ~pin_s2_r;
   assign pin_both = pin_s3_r ^ pin_s2_r;

   // Hardware sources indexed by primary code; reserved are 0
   assign hw_vec = {i_adc_req, 4'h0, i_uart_rx_req[2],
      i_uart_tx_req[2], i_uart_rx_req[1], i_uart_tx_req[1],
      i_uart_rx_req[0], i_uart_tx_req[0], i_timer_b_req,
      i_timer_a_req, 3'h0};

   // ======================================================
   // Avalon slave: one wait cycle, answer in the second
   assign wr_go = i_avs_write && !wait_r;
   assign a_ch  = i_avs_address[CH_SH +: 2];
   assign a_ofs = i_avs_address[CH_SH-1:0];

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0;
      if (i_avs_address == ADR_STATUS) begin
         rd_mux = {21'h0, act_r, st_r != ST_IDLE, enabled, pend_r};
      end else if (!i_avs_address[7]) begin
         if (a_ofs == OFS_MODE) begin
            rd_mux = {26'h0, ctl_r[a_ch]};
         end else if (a_ofs == OFS_COUNT) begin
            rd_mux = {7'h0, cnt_r[a_ch]};
         end else if (a_ofs == OFS_RELOAD) begin
            rd_mux = {7'h0, rl_r[a_ch]};
         end else if (a_ofs == OFS_SRC) begin
            rd_mux = src_r[a_ch];
         end else if (a_ofs == OFS_SRC_RL) begin
            rd_mux = srl_r[a_ch];
         end else if (a_ofs == OFS_DST) begin
            rd_mux = dst_r[a_ch];
         end else if (a_ofs == OFS_DST_RL) begin
            rd_mux = drl_r[a_ch];
         end else if (a_ofs == OFS_SEL) begin
            rd_mux = {19'h0, sel_r[a_ch]};
         end
      end
   end

   // Handshake and registered read data
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         wait_r         <= 1'b1;
         o_avs_readdata <= 32'h0;
      end else if ((i_avs_read || i_avs_write) && wait_r) begin
         wait_r         <= 1'b0;
         o_avs_readdata <= i_avs_read ? rd_mux : 32'h0;
      end else begin
         wait_r <= 1'b1;
      end
   end
   assign o_avs_waitrequest = wait_r;

   // ======================================================
   // Request detection and pending flags
   always_comb begin
      pick = 2'h0;
      for (int c = NCH - 1; c >= 0; c--) begin
         sw_hit[c]  = wr_go && !i_avs_address[7] && a_ch == 2'(c)
            && a_ofs == OFS_SEL && i_avs_byteenable[2]
            && i_avs_writedata[SW_POS];
         enabled[c] = ctl_r[c][MODE_POS] && cnt_r[c] != RST_CNT;
         req_hit[c] = enabled[c] && sel_req(2'(c), sel_r[c],
            sw_hit[c], pin_fall[c], pin_both[c]);
         elig[c]    = pend_r[c] && enabled[c];
         if (elig[c]) begin
            pick = 2'(c);
         end
      end
      take = (st_r == ST_IDLE && elig != 4'h0) ? (4'h1 << pick) : 4'h0;
   end

   // Flags only remember that a request came, never how many;
   // a new trigger beats the clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         pend_r <= 4'h0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (req_hit[c]) begin
               pend_r[c] <= 1'b1;
            end else if (take[c] || !enabled[c]) begin
               pend_r[c] <= 1'b0;
            end
         end
      end
   end

   // ======================================================
   // Channel registers: software writes and transfer updates
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         for (int c = 0; c < NCH; c++) begin
            ctl_r[c] <= RST_CTL;
            sel_r[c] <= RST_SEL;
            cnt_r[c] <= RST_CNT;
            rl_r[c]  <= RST_CNT;
            src_r[c] <= RST_PTR;
            srl_r[c] <= RST_PTR;
            dst_r[c] <= RST_PTR;
            drl_r[c] <= RST_PTR;
         end
      end else begin
         if (st_r == ST_DECR) begin
            if (cnt_r[act_r] == CNT_ONE &&
                ctl_r[act_r][MODE_POS +: 2] == MODE_REPEAT) begin
               cnt_r[act_r] <= rl_r[act_r];
               src_r[act_r] <= srl_r[act_r];
               dst_r[act_r] <= drl_r[act_r];
            end else begin
               cnt_r[act_r] <= cnt_r[act_r] - CNT_ONE;
               if (ctl_r[act_r][SINC_POS]) begin
                  src_r[act_r] <= src_r[act_r] + 32'(szb_r);
               end
               if (ctl_r[act_r][DINC_POS]) begin
                  dst_r[act_r] <= dst_r[act_r] + 32'(szb_r);
               end
            end
         end
         if (wr_go && !i_avs_address[7]) begin
            if (a_ofs == OFS_MODE) begin
               ctl_r[a_ch] <= 6'(merge({26'h0, ctl_r[a_ch]},
                  i_avs_writedata, i_avs_byteenable));
            end else if (a_ofs == OFS_COUNT) begin
               cnt_r[a_ch] <= CNT_W'(merge({7'h0, cnt_r[a_ch]},
                  i_avs_writedata, i_avs_byteenable));
            end else if (a_ofs == OFS_RELOAD) begin
               rl_r[a_ch] <= CNT_W'(merge({7'h0, rl_r[a_ch]},
                  i_avs_writedata, i_avs_byteenable));
            end else if (a_ofs == OFS_SRC) begin
               src_r[a_ch] <= merge(src_r[a_ch], i_avs_writedata,
                  i_avs_byteenable);
            end else if (a_ofs == OFS_SRC_RL) begin
               srl_r[a_ch] <= merge(srl_r[a_ch], i_avs_writedata,
                  i_avs_byteenable);
            end else if (a_ofs == OFS_DST) begin
               dst_r[a_ch] <= merge(dst_r[a_ch], i_avs_writedata,
                  i_avs_byteenable);
            end else if (a_ofs == OFS_DST_RL) begin
               drl_r[a_ch] <= merge(drl_r[a_ch], i_avs_writedata,
                  i_avs_byteenable);
            end else if (a_ofs == OFS_SEL) begin
               sel_r[a_ch] <= 13'(merge({19'h0, sel_r[a_ch]},
                  i_avs_writedata, i_avs_byteenable));
            end
         end
      end
   end

   // ======================================================
   // Transfer engine; size is latched at acceptance so a
   // later disable cannot cut an accepted item short
   assign piece_w = csd_piece(o_mem_addr[2:0], i_bus_width, rem_r);
   assign rd_in   = (i_mem_rdata & ((32'h1 << {piece_w, 3'h0})
      - 32'h1)) << {got_r, 3'h0};
   assign act_src = src_r[act_r];

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st_r         <= ST_IDLE;
         act_r        <= 2'h0;
         szb_r        <= 3'h1;
         rem_r        <= 3'h0;
         got_r        <= 3'h0;
         data_r       <= 32'h0;
         o_bus_hold   <= 1'b0;
         o_mem_req    <= 1'b0;
         o_mem_we     <= 1'b0;
         o_mem_addr   <= 32'h0;
         o_mem_nbytes <= 3'h0;
         o_mem_wdata  <= 32'h0;
         o_xfer_done  <= 4'h0;
      end else begin
         o_xfer_done <= 4'h0;
         case (st_r)
            ST_IDLE: begin
               if (elig != 4'h0) begin
                  act_r        <= pick;
                  szb_r        <= csd_item_bytes(ctl_r[pick][SIZE_POS +: 2]);
                  rem_r        <= csd_item_bytes(ctl_r[pick][SIZE_POS +: 2]);
                  o_mem_nbytes <= csd_item_bytes(ctl_r[pick][SIZE_POS +: 2]);
                  got_r        <= 3'h0;
                  data_r       <= 32'h0;
                  o_bus_hold   <= 1'b1;
                  o_mem_req    <= 1'b1;
                  o_mem_we     <= 1'b0;
                  o_mem_addr   <= src_r[pick];
                  st_r         <= ST_READ;
               end
            end
            ST_READ: begin
               if (i_mem_ack) begin
                  if (rem_r == piece_w) begin
                     o_mem_wdata  <= data_r | rd_in;
                     o_mem_we     <= 1'b1;
                     o_mem_addr   <= dst_r[act_r];
                     o_mem_nbytes <= szb_r;
                     rem_r        <= szb_r;
                     st_r         <= ST_WRITE;
                  end else begin
                     data_r       <= data_r | rd_in;
                     got_r        <= got_r + piece_w;
                     o_mem_addr   <= o_mem_addr + 32'(piece_w);
                     o_mem_nbytes <= rem_r - piece_w;
                     rem_r        <= rem_r - piece_w;
                  end
               end
            end
            ST_WRITE: begin
               if (i_mem_ack) begin
                  if (rem_r == piece_w) begin
                     o_mem_req <= 1'b0;
                     o_mem_we  <= 1'b0;
                     st_r      <= ST_DECR;
                  end else begin
                     o_mem_wdata  <= o_mem_wdata >> {piece_w, 3'h0};
                     o_mem_addr   <= o_mem_addr + 32'(piece_w);
                     o_mem_nbytes <= rem_r - piece_w;
                     rem_r        <= rem_r - piece_w;
                  end
               end
            end
            ST_DECR: begin
               o_xfer_done[act_r] <= cnt_r[act_r] == CNT_ONE;
               o_bus_hold         <= 1'b0;
               st_r               <= ST_YIELD;
            end
            ST_YIELD: begin
               // Hold off until the CPU has had one access or is not requesting the bus
               if (i_cpu_access_done || !i_cpu_bus_req) begin
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ======================================================
   // Checks
   AST_PRIORITY: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_IDLE && elig[0]) |=> (act_r == 2'h0 && st_r == ST_READ))
      else $error("channel 0 not served first");
   AST_BUS_WIN: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_IDLE && elig != 4'h0) |=> o_bus_hold && o_mem_req)
      else $error("bus not taken for pending channel");
   AST_YIELD: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_DECR) |=> (!o_bus_hold && st_r == ST_YIELD))
      else $error("bus not returned after transfer");
   AST_DONE: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_DECR && cnt_r[act_r] == CNT_ONE) |=> o_xfer_done[act_r])
      else $error("no done pulse at count one to zero");
   AST_RELOAD: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_DECR && cnt_r[act_r] == CNT_ONE
      && ctl_r[act_r][MODE_POS +: 2] == MODE_REPEAT && !wr_go)
      |=> (cnt_r[act_r] == rl_r[act_r] && act_src == srl_r[act_r]))
      else $error("repeat reload missing");
   AST_STEP: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_DECR && cnt_r[act_r] != CNT_ONE && !wr_go
      && ctl_r[act_r][SINC_POS])
      |=> act_src == $past(act_src) + 32'(szb_r))
      else $error("source pointer step wrong");
   AST_IDLE_STAYS: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_IDLE && elig == 4'h0) |=> st_r == ST_IDLE)
      else $error("transfer without eligible request");
   AST_SPLIT: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_READ && i_mem_ack && rem_r == 3'h4
      && o_mem_addr[1:0] == 2'h1 && i_bus_width == BW_32)
      |=> (st_r == ST_READ && rem_r == 3'h1))
      else $error("misaligned long read not split");
   AST_ONE_ITEM: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == ST_IDLE && elig != 4'h0)
      |=> !pend_r[act_r] || $past(req_hit[pick]))
      else $error("pending flag kept after acceptance");
endmodule : csd_dma_top

// ---- csd_mem_model.sv ----
// Partner model: CPU and byte-wide memory on the shared data bus
`timescale 1ns/1ps
module csd_mem_model
   import csd_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [31:0] i_addr,
   input  wire logic [2:0]  i_nbytes,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_hold,
   output logic      [31:0] o_rdata,
   output logic             o_ack = 1'b0,
   output logic      [1:0]  o_width,
   output logic             o_cpu_done = 1'b0
);
   // ======================================================
   // Memory and read path
   logic [7:0] mem [256];
   logic [7:0] a;
   logic [2:0] lane, n;
   assign a = i_addr[7:0];
   assign o_width = BW_32;
   assign lane = 3'h4 - {1'b0, i_addr[1:0]};
   assign n = (i_nbytes < lane) ? i_nbytes : lane;
   // Idle bus shows inverted data so stale values never match
   assign o_rdata = {mem[a+8'h3], mem[a+8'h2], mem[a+8'h1], mem[a]}
                    ^ {32{~(i_req & ~i_we)}};
   // Slow slave: every bus cycle waits one extra clock
   always @(posedge i_mclk) begin
      o_ack <= i_req & ~o_ack;
      o_cpu_done <= ~i_hold & ~o_cpu_done;
      if (i_req && i_we && o_ack)
         for (int i = 0; i < 4; i++)
            if (i < n) mem[a + 8'(i)] <= i_wdata[8*i +: 8];
   end
endmodule : csd_mem_model

// ---- csd_dma_top_tb.sv ----
// Testbench: register tasks and directed DMA scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   miscompares++; $display("mismatch %0t %h", $time, a); end end
module csd_dma_top_tb
   import csd_pkg::*;
   ;
   // ======================================================
   // Stimulus and observed signals
   logic i_mclk = 0, i_reset = 1, i_avs_read = 0, i_avs_write = 0;
   logic [7:0] i_avs_address = 0;
   logic [31:0] i_avs_writedata = 0, o_avs_readdata, rdat, o_mem_addr;
   logic [31:0] o_mem_wdata, i_mem_rdata;
   logic [4:0] i_timer_a_req = 0;
   logic [5:0] i_timer_b_req = 0;
   logic [2:0] i_uart_tx_req = 0, i_uart_rx_req = 0, o_mem_nbytes;
   logic [11:0] i_iio_req = 0;
   logic [1:0] i_sbi_req = 0, i_bus_width;
   logic [3:0] i_uart34_req = 0, o_xfer_done, pin = 4'hf;
   logic i_adc_req = 0, o_avs_waitrequest, o_bus_hold, o_mem_req;
   logic o_mem_we, i_mem_ack, i_cpu_access_done;
   logic [31:0] q[$];
   int miscompares = 0, total_checks = 0;
   csd_dma_top DUT (.i_mclk, .i_reset, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf),
      .o_avs_readdata, .o_avs_waitrequest, .i_ext_request_pin(pin),
      .i_timer_a_req, .i_timer_b_req, .i_uart_tx_req, .i_uart_rx_req,
      .i_adc_req, .i_iio_req, .i_sbi_req, .i_uart34_req, .o_bus_hold,
      .i_cpu_bus_req(1'b1), .i_cpu_access_done, .o_mem_req, .o_mem_we,
      .o_mem_addr, .o_mem_nbytes, .o_mem_wdata, .i_mem_rdata, .i_mem_ack,
      .i_bus_width, .o_xfer_done);
   csd_mem_model M (.i_mclk, .i_req(o_mem_req), .i_we(o_mem_we),
      .i_addr(o_mem_addr), .i_nbytes(o_mem_nbytes), .i_wdata(o_mem_wdata),
      .i_hold(o_bus_hold), .o_rdata(i_mem_rdata), .o_ack(i_mem_ack),
      .o_width(i_bus_width), .o_cpu_done(i_cpu_access_done));
   // ======================================================
   // Clock, watchdog and source-read address log
   initial forever #2 i_mclk = ~i_mclk;
   initial begin
      repeat (20000) @(posedge i_mclk);
      miscompares++;
      complete_run();
   end
   always @(posedge i_mclk)
      if (o_mem_req && !o_mem_we && i_mem_ack) q.push_back(o_mem_addr);
   // ======================================================
   // Avalon access: hold the request until waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= ~w;
      do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0);
      rdat = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask : acc
   function automatic logic [7:0] ra(int c, logic [4:0] o);
      return {1'b0, 2'(c), o};
   endfunction : ra
   task automatic rchk(int c, logic [4:0] o, logic [31:0] e);
      acc(0, ra(c, o), '0);
      `CHK(rdat, e)
   endtask : rchk
   // Select is written first so enough clocks pass before the mode
   task automatic cfg(int c, logic [31:0] s, cn, sa, da, md);
      acc(1, ra(c, OFS_SEL), s);
      acc(1, ra(c, OFS_COUNT), cn);
      acc(1, ra(c, OFS_RELOAD), 32'h3);
      acc(1, ra(c, OFS_SRC), sa);
      acc(1, ra(c, OFS_SRC_RL), 32'h80);
      acc(1, ra(c, OFS_DST), da);
      acc(1, ra(c, OFS_DST_RL), 32'ha0);
      acc(1, ra(c, OFS_MODE), md);
   endtask : cfg
   task automatic waitd(int c);
      int n;
      n = 0;
      while (o_xfer_done[c] !== 1'b1 && n < 300) begin
         @(posedge i_mclk);
         n++;
      end
      `CHK(n < 300, 1'b1)
   endtask : waitd
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // ======================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 256; i++) M.mem[i] = 8'(i) ^ 8'h5a;
      repeat (6) @(posedge i_mclk);
      i_reset <= 1'b0;
      rchk(0, OFS_COUNT, 0);
      acc(0, 8'hfc, '0);
      `CHK(rdat, 32'h0)
      cfg(0, 0, 1, 32'h10, 32'h40, 32'h39);
      acc(1, ra(0, OFS_SEL), 32'h1_0000);
      waitd(0);
      `CHK({M.mem[67], M.mem[66], M.mem[65], M.mem[64]}, 32'h49484b4a)
      rchk(0, OFS_COUNT, 0);
      rchk(0, OFS_SRC, 32'h14);
      acc(1, ra(0, OFS_SEL), 32'h1_0000);
      repeat (30) @(posedge i_mclk);
      rchk(0, OFS_DST, 32'h44);
      $display("single mode test done");
      cfg(1, 0, 1, 32'h20, 32'h50, 32'h37);
      acc(1, ra(1, OFS_SEL), 32'h1_0000);
      waitd(1);
      `CHK({M.mem[81], M.mem[80]}, 16'h7b7a)
      rchk(1, OFS_COUNT, 3);
      rchk(1, OFS_SRC, 32'h80);
      rchk(1, OFS_DST, 32'ha0);
      $display("repeat mode test done");
      cfg(2, PRI_TA0, 1, 32'h30, 32'h60, 32'h31);
      cfg(3, PRI_TA0, 1, 32'h34, 32'h64, 32'h31);
      cfg(0, 32'h14, 1, 32'h10, 32'h40, 32'h39);
      q.delete();
      i_timer_a_req <= '1;
      i_adc_req <= 1'b1;
      @(posedge i_mclk);
      i_timer_a_req <= '0;
      i_adc_req <= 1'b0;
      waitd(3);
      `CHK(q[0], 32'h30)
      `CHK(q[1], 32'h34)
      rchk(0, OFS_COUNT, 1);
      acc(1, ra(1, OFS_MODE), 32'h34);
      acc(1, ra(1, OFS_SEL), 32'h1_0000);
      repeat (30) @(posedge i_mclk);
      rchk(1, OFS_COUNT, 3);
      $display("priority and disable test done");
      // Falling edge on channel 2's own pin requests one byte
      cfg(2, PRI_FALL, 1, 32'h30, 32'h70, 32'h31);
      pin[2] <= 1'b0;
      waitd(2);
      `CHK(M.mem[112], 8'h6a)
      $display("pin edge test done");
      complete_run();
   end
endmodule : csd_dma_top_tb
